/* logic/cgc_defines.svh */
// Constants of the CAN general control block
//
// Summary of operation
// - Abort bit set clears every message object enable; hardware never clears the abort bit.
// - Abort drops waiting transmissions at once; a frame already on the bus completes.
// - Overload bit requests an overload frame; cleared when that frame starts.
// - Time-triggered bit set enables time-triggered mode; clear disables its features.
// - Capture select picks end-of-frame or start-of-frame; it matters only in time-triggered mode.
// - Listen bit set enters listening mode; clearing it restores normal operation.
// - Run bit set enables the controller and ungates its input clock.
// - Clearing run lets the current frame finish, then freezes; object enables stay.
// - In standby transmit stays recessive, receiver is off, input clock is stopped.
// - Registers stay readable and writable while the controller is disabled.
// - The state machine starts two clock periods after the controller is enabled.
// - Writing one to bit 0 gives a self-clearing reset; controller ends disabled.
// - The general control register resets to all zeros.
// - Listening mode never acknowledges or transmits but keeps updating error flags.
// - Listening mode holds both error counters.
// - Time-triggered mode copies the 16-bit timer into the capture pair.
// - Time-triggered mode sends each frame once, without retransmission.
`ifndef CGC_DEFINES_SVH
`define CGC_DEFINES_SVH

// Register addresses in special-function space
`define CGC_GC_ADDR 8'hAB
`define CGC_CAPL_ADDR 8'hA4
`define CGC_CAPH_ADDR 8'hA5

// General control bit positions
`define CGC_BIT_ABORT 7
`define CGC_BIT_OVL 6
`define CGC_BIT_TTC 5
`define CGC_BIT_SYNC 4
`define CGC_BIT_LISTEN 3
`define CGC_BIT_TEST 2
`define CGC_BIT_RUN 1
`define CGC_BIT_SOFT_GENERAL_RESET 0

// Reset values and timing
`define CGC_GC_RESET 8'h00
`define CGC_CAP_RESET 16'h0000
`define CGC_START_CYCLES 2'h2

`endif

/* logic/cgc_pkg.sv */
// Types shared by the CAN general control block
package cgc_pkg;
  typedef enum logic [1:0] {
    CGC_OFF = 2'b00,
    CGC_START = 2'b01,
    CGC_RUN = 2'b10,
    CGC_DRAIN = 2'b11
  } cgc_seq_state_t;
endpackage : cgc_pkg

/* logic/cgc_run_seq.sv */
// Enable, standby and start-up sequencer of the CAN controller
`timescale 1ns/100ps
`default_nettype none
module cgc_run_seq
  import cgc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  cgc_seq_if.seq sif
);
`include "cgc_defines.svh"

  cgc_seq_state_t state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  logic clk_en_q, sm_run_q;

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (sif.soft_rst) begin
      state_d = CGC_OFF;
      cnt_d = 2'h0;
    end else begin
      case (state_q)
        CGC_OFF: begin
          cnt_d = 2'h0;
          if (sif.run_req) begin
            state_d = CGC_START; // Clock ungated here
          end
        end
        CGC_START: begin
          if (!sif.run_req) begin
            state_d = CGC_OFF;
          end else if (cnt_q == `CGC_START_CYCLES - 2'h1) begin
            state_d = CGC_RUN; // Two-period start-up
          end else begin
            cnt_d = cnt_q + 2'h1;
          end
        end
        CGC_RUN: begin
          if (!sif.run_req) begin
            state_d = sif.frame_active ? CGC_DRAIN : CGC_OFF;
          end
        end
        CGC_DRAIN: begin
          if (sif.run_req) begin
            state_d = CGC_RUN;
          end else if (!sif.frame_active) begin
            state_d = CGC_OFF; // Freeze once the frame has ended
          end
        end
        default: begin
          state_d = CGC_OFF;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // State and output flops
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= CGC_OFF;
      cnt_q <= 2'h0;
      clk_en_q <= 1'b0;
      sm_run_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      clk_en_q <= (state_d != CGC_OFF); // Clock stopped in standby
      sm_run_q <= (state_d == CGC_RUN) || (state_d == CGC_DRAIN);
    end
  end

  assign sif.clk_en = clk_en_q;
  assign sif.sm_run = sm_run_q;
endmodule : cgc_run_seq
`default_nettype wire

/* logic/cgc_seq_if.sv */
// Carrier between the control register and the run sequencer
`timescale 1ns/100ps
`default_nettype none
interface cgc_seq_if;
  logic run_req;
  logic soft_rst;
  logic frame_active;
  logic clk_en;
  logic sm_run;
  modport ctrl (output run_req, output soft_rst, output frame_active, input clk_en, input sm_run);
  modport seq (input run_req, input soft_rst, input frame_active, output clk_en, output sm_run);
endinterface : cgc_seq_if
`default_nettype wire

/* logic/cgc_top.sv */
// General control register and mode logic of the CAN controller
`timescale 1ns/100ps
`default_nettype none
module cgc_top
  import cgc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_frame_active,
  input wire logic i_sof,
  input wire logic i_eof_last,
  input wire logic i_ovl_tx_start,
  input wire logic [15:0] i_timer,
  input wire logic i_core_txd,
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_core_rxd,
  output logic o_abort_objects,
  output logic o_overload_req,
  output logic o_ttc_mode,
  output logic o_single_shot,
  output logic o_listen_mode,
  output logic o_err_cnt_hold,
  output logic o_clk_en,
  output logic o_sm_run,
  output logic o_ctrl_reset
);
`include "cgc_defines.svh"

  cgc_seq_if sif();

  logic [7:0] gc_q, gc_d;
  logic [15:0] cap_q, cap_d;
  logic [7:0] rdata_q, rdata_d;
  logic soft_rst_q;
  logic rx_meta_q, rx_sync_q;
  logic txd_q, rxd_q, abort_q, ovl_q, ttc_q, single_q, listen_q, hold_q;

  // --------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------
  wire wr_gc = i_sfr_wr && (i_sfr_addr == `CGC_GC_ADDR);
  wire soft_general_reset_wr = wr_gc && i_sfr_wdata[`CGC_BIT_SOFT_GENERAL_RESET];
  wire ovl_keep = gc_q[`CGC_BIT_OVL] && !i_ovl_tx_start;
  wire ttc_on = gc_q[`CGC_BIT_TTC];
  wire cap_hit = gc_q[`CGC_BIT_SYNC] ? i_eof_last : i_sof;
  wire cap_now = ttc_on && cap_hit;
  wire tx_allow = sif.sm_run && !gc_q[`CGC_BIT_LISTEN];

  // Control register next value; soft reset zeroes it, set beats clear on bit 6
  always_comb begin
    gc_d = gc_q;
    if (soft_general_reset_wr) begin
      gc_d = `CGC_GC_RESET; // Leaves controller disabled
    end else if (wr_gc) begin
      gc_d = {i_sfr_wdata[7], i_sfr_wdata[6] | ovl_keep, i_sfr_wdata[5:1], 1'b0};
    end else begin
      gc_d[`CGC_BIT_OVL] = ovl_keep; // Cleared as the overload frame starts
    end
  end

  // Capture pair next value
  always_comb begin
    cap_d = cap_q;
    if (soft_rst_q) begin
      cap_d = `CGC_CAP_RESET;
    end else if (cap_now) begin
      cap_d = i_timer; // Point chosen by capture select
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = rdata_q;
    if (i_sfr_rd) begin
      case (i_sfr_addr)
        `CGC_GC_ADDR: rdata_d = gc_q;
        `CGC_CAPL_ADDR: rdata_d = cap_q[7:0];
        `CGC_CAPH_ADDR: rdata_d = cap_q[15:8];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Register flops
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gc_q <= `CGC_GC_RESET;
      cap_q <= `CGC_CAP_RESET;
      rdata_q <= 8'h00;
      soft_rst_q <= 1'b0;
    end else begin
      gc_q <= gc_d;
      cap_q <= cap_d;
      rdata_q <= rdata_d;
      soft_rst_q <= soft_general_reset_wr; // One-cycle reset pulse
    end
  end

  // Receive pin synchroniser
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= i_rxd;
      rx_sync_q <= rx_meta_q;
    end
  end

  // Mode outputs and pin gating
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      txd_q <= 1'b1;
      rxd_q <= 1'b1;
      abort_q <= 1'b0;
      ovl_q <= 1'b0;
      ttc_q <= 1'b0;
      single_q <= 1'b0;
      listen_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      txd_q <= tx_allow ? i_core_txd : 1'b1; // Recessive in standby and listening
      rxd_q <= sif.sm_run ? rx_sync_q : 1'b1; // Receiver idle in standby
      abort_q <= gc_q[`CGC_BIT_ABORT]; // Clears object enables, drops waiting frames
      ovl_q <= gc_q[`CGC_BIT_OVL];
      ttc_q <= ttc_on;
      single_q <= ttc_on; // No retransmission
      listen_q <= gc_q[`CGC_BIT_LISTEN]; // No ack, no transmit
      hold_q <= gc_q[`CGC_BIT_LISTEN]; // Error counters frozen
    end
  end

  // --------------------------------------------------------------
  // Sequencer hookup
  // --------------------------------------------------------------
  assign sif.run_req = gc_q[`CGC_BIT_RUN];
  assign sif.soft_rst = soft_rst_q;
  assign sif.frame_active = i_frame_active;

  cgc_run_seq u_seq (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .sif(sif.seq)
  );

  // Output assignments, all from flops
  assign o_sfr_rdata = rdata_q;
  assign o_txd = txd_q;
  assign o_core_rxd = rxd_q;
  assign o_abort_objects = abort_q;
  assign o_overload_req = ovl_q;
  assign o_ttc_mode = ttc_q;
  assign o_single_shot = single_q;
  assign o_listen_mode = listen_q;
  assign o_err_cnt_hold = hold_q;
  assign o_clk_en = sif.clk_en;
  assign o_sm_run = sif.sm_run;
  assign o_ctrl_reset = soft_rst_q;

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_soft_reset_clear: assert property (soft_general_reset_wr |=> gc_q == 8'h00 && o_ctrl_reset ##1 (!o_ctrl_reset || $past(soft_general_reset_wr)))
    else $error("soft reset did not clear control or pulse once");
  a_abort_follows: assert property (gc_q[7] && !wr_gc |=> gc_q[7] && o_abort_objects)
    else $error("abort bit cleared by hardware or not forwarded");
  a_overload_clear: assert property (gc_q[6] && i_ovl_tx_start && !wr_gc |=> !gc_q[6])
    else $error("overload request not cleared at overload start");
  a_overload_set_wins: assert property (wr_gc && i_sfr_wdata[6] && !i_sfr_wdata[0] |=> gc_q[6])
    else $error("overload request write lost");
  a_standby_recessive: assert property (!sif.sm_run |=> o_txd && o_core_rxd)
    else $error("pins active in standby");
  a_listen_silent: assert property (gc_q[3] |=> o_txd && o_err_cnt_hold && o_listen_mode)
    else $error("listening mode transmitted or released counters");
  a_start_delay: assert property ($rose(sif.clk_en) |-> !sif.sm_run [*2] ##1 (sif.sm_run || !sif.clk_en))
    else $error("state machine start not two periods after enable");
  a_eof_capture: assert property (gc_q[5] && gc_q[4] && i_eof_last && !soft_rst_q |=> cap_q == $past(i_timer))
    else $error("end-of-frame capture missed");
  a_no_capture_off: assert property (!gc_q[5] && !soft_rst_q |=> $stable(cap_q))
    else $error("capture outside time-triggered mode");
  a_drain_frame: assert property (sif.sm_run && !gc_q[1] && i_frame_active && !soft_rst_q |=> sif.sm_run)
    else $error("frame cut short by standby");
  a_disabled_write: assert property (wr_gc && !sif.clk_en && !i_sfr_wdata[0] |=> gc_q[5:1] == $past(i_sfr_wdata[5:1]))
    else $error("register write lost while disabled");
  a_single_shot: assert property (gc_q[5] |=> o_single_shot && o_ttc_mode)
    else $error("time-triggered single shot not driven");

  // Capture, clock enable, pin paths, read data and forwarded levels
  a_sof_capture: assert property (gc_q[5] && !gc_q[4] && i_sof && !soft_rst_q |=> cap_q == $past(i_timer))
    else $error("start-of-frame capture missed");
  a_capture_clear: assert property (soft_rst_q |=> cap_q == `CGC_CAP_RESET)
    else $error("capture pair not cleared by soft reset");
  a_abort_release: assert property (!gc_q[7] |=> !o_abort_objects)
    else $error("abort output held without request");
  a_ovl_forward: assert property (gc_q[6] |=> o_overload_req)
    else $error("overload request not forwarded");
  a_run_clock: assert property (gc_q[1] && !sif.clk_en && !soft_rst_q |=> sif.clk_en)
    else $error("clock not ungated after enable");
  a_tx_follows: assert property (tx_allow |=> o_txd == $past(i_core_txd))
    else $error("transmit pin does not follow core");
  a_rx_follows: assert property (sif.sm_run |=> o_core_rxd == $past(rx_sync_q))
    else $error("receive path does not follow bus");
  a_read_data: assert property (i_sfr_rd && i_sfr_addr == `CGC_GC_ADDR |=> o_sfr_rdata == $past(gc_q))
    else $error("control register read data wrong");

  // Main scenarios reached
  c_enable: cover property ($rose(sif.sm_run));
  c_listen: cover property ($rose(o_listen_mode));
  c_drain: cover property (sif.sm_run && !gc_q[1] && i_frame_active ##1 sif.sm_run);
  c_abort: cover property ($rose(o_abort_objects));
  c_capture: cover property (cap_now && gc_q[4]);
endmodule : cgc_top
`default_nettype wire

/* sim/can_general_control_tb_top.sv */
// Self-checking bench for the CAN general control block
`timescale 1ns/100ps
`default_nettype none
module can_general_control_tb_top;
  logic clk = 0, resetn = 0, wr = 0, rd = 0, go = 0, ovl = 0, ctxd = 1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [15:0] timer = 16'h0000, exp_sof = 16'h0000, exp_eof = 16'h0000;
  logic fa, sof, eof, rxd, txd, crxd, abrt, ovr, time_triggered_mode, ss, lsn, hold, cen, smr, crst;
  int failures = 0, n_tests = 0;
  // ----------------------------------------
  // Clock, free-running timer, capture expectations
  // ----------------------------------------
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) timer <= timer + 16'h0001;
  always @(posedge clk) begin
    if (sof)
      exp_sof <= timer;
    if (eof)
      exp_eof <= timer;
  end
  cgc_top u_dut (.i_clk(clk), .i_resetn(resetn), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
    .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_frame_active(fa), .i_sof(sof), .i_eof_last(eof),
    .i_ovl_tx_start(ovl), .i_timer(timer), .i_core_txd(ctxd), .i_rxd(rxd), .o_txd(txd),
    .o_core_rxd(crxd), .o_abort_objects(abrt), .o_overload_req(ovr), .o_ttc_mode(time_triggered_mode),
    .o_single_shot(ss), .o_listen_mode(lsn), .o_err_cnt_hold(hold), .o_clk_en(cen),
    .o_sm_run(smr), .o_ctrl_reset(crst));
  cgc_bus_node u_node (.i_clk(clk), .i_go(go), .o_frame_active(fa), .o_sof(sof),
    .o_eof_last(eof), .o_rxd(rxd));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] s, input logic [15:0] e, input string m);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, m, s, e);
    end
  endtask : chk
  task automatic chk1(input logic s, input logic e, input string m);
    chk({15'h0000, s}, {15'h0000, e}, m);
  endtask : chk1
  task automatic results;
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input string m);
    @(negedge clk);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    chk({8'h00, rdata}, {8'h00, e}, m);
  endtask : rd_reg
  task automatic frame;
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
  endtask : frame
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_enable;
    int n;
    chk1(txd, 1'b1, "idle txd");
    chk1(cen, 1'b0, "gated after reset");
    rd_reg(8'hAB, 8'h00, "reset value");
    rd_reg(8'h55, 8'h00, "unmapped read");
    wr_reg(8'hAB, 8'h02);
    for (n = 0; n < 4 && cen !== 1'b1; n++) @(negedge clk);
    chk1(cen, 1'b1, "clock on");
    for (n = 0; n < 6 && smr !== 1'b1; n++) @(negedge clk);
    chk(16'(n), 16'h0002, "start delay");
    ctxd = 0;
    cyc(2);
    chk1(txd, 1'b0, "txd follows core");
  endtask : t_enable
  task automatic t_listen;
    wr_reg(8'hAB, 8'h0A);
    cyc(2);
    chk1(lsn, 1'b1, "listen on");
    chk1(hold, 1'b1, "counters held");
    chk1(txd, 1'b1, "no transmit");
    wr_reg(8'hAB, 8'h02);
    cyc(2);
    chk1(txd, 1'b0, "normal again");
    ctxd = 1;
  endtask : t_listen
  task automatic t_abort_ovl;
    wr_reg(8'hAB, 8'h82);
    frame();
    cyc(5);
    chk1(crxd, 1'b1, "receiver bit one");
    cyc(1);
    chk1(crxd, 1'b0, "receiver bit zero");
    cyc(8);
    chk1(abrt, 1'b1, "abort level");
    rd_reg(8'hAB, 8'h82, "abort kept");
    wr_reg(8'hAB, 8'h42);
    cyc(2);
    chk1(abrt, 1'b0, "abort cleared");
    chk1(ovr, 1'b1, "overload req");
    ovl = 1;
    cyc(1);
    ovl = 0;
    cyc(2);
    chk1(ovr, 1'b0, "overload done");
    rd_reg(8'hAB, 8'h02, "overload bit");
  endtask : t_abort_ovl
  task automatic t_ttc;
    logic [15:0] last;
    wr_reg(8'hAB, 8'h22);
    cyc(2);
    chk1(time_triggered_mode, 1'b1, "ttc on");
    chk1(ss, 1'b1, "single shot");
    frame();
    cyc(14);
    rd_reg(8'hA4, exp_sof[7:0], "sof low");
    rd_reg(8'hA5, exp_sof[15:8], "sof high");
    wr_reg(8'hAB, 8'h32);
    frame();
    cyc(14);
    rd_reg(8'hA4, exp_eof[7:0], "eof low");
    rd_reg(8'hA5, exp_eof[15:8], "eof high");
    last = exp_eof;
    wr_reg(8'hAB, 8'h12);
    frame();
    cyc(14);
    chk1(time_triggered_mode, 1'b0, "ttc off");
    rd_reg(8'hA4, last[7:0], "no capture");
    wr_reg(8'hAB, 8'h02);
  endtask : t_ttc
  task automatic t_standby;
    int n;
    frame();
    cyc(3);
    wr_reg(8'hAB, 8'h00);
    cyc(2);
    chk1(cen, 1'b1, "frame finishes");
    chk1(smr, 1'b1, "still running");
    for (n = 0; n < 20 && fa === 1'b1; n++) @(negedge clk);
    cyc(2);
    chk1(cen, 1'b0, "clock stopped");
    chk1(smr, 1'b0, "frozen");
    ctxd = 0;
    frame();
    cyc(4);
    chk1(txd, 1'b1, "recessive");
    chk1(crxd, 1'b1, "receiver off");
    wr_reg(8'hAB, 8'h08);
    rd_reg(8'hAB, 8'h08, "access in standby");
    ctxd = 1;
    cyc(10);
  endtask : t_standby
  task automatic t_soft_reset;
    int n;
    int k;
    wr_reg(8'hAB, 8'h2A);
    cyc(6);
    wr_reg(8'hAB, 8'h2B);
    k = 0;
    for (n = 0; n < 3; n++) begin
      if (crst === 1'b1)
        k++;
      @(negedge clk);
    end
    chk(16'(k), 16'h0001, "reset pulse");
    cyc(1);
    chk1(cen, 1'b0, "disabled");
    chk1(time_triggered_mode, 1'b0, "modes cleared");
    rd_reg(8'hAB, 8'h00, "register cleared");
  endtask : t_soft_reset
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    resetn = 1;
    t_enable();
    t_listen();
    t_abort_ovl();
    t_ttc();
    t_standby();
    t_soft_reset();
    results();
  end
endmodule : can_general_control_tb_top
`default_nettype wire

/* sim/cgc_bus_node.sv */
// Behavioural model of another CAN node sending frames to the controller
`timescale 1ns/100ps
`default_nettype none
module cgc_bus_node #(
  parameter int FLEN = 12
) (
  input wire logic i_clk,
  input wire logic i_go,
  output logic o_frame_active,
  output logic o_sof,
  output logic o_eof_last,
  output logic o_rxd
);
  int cnt = 0;
  // Frame sequencer, moves on the falling edge like the bench
  always @(negedge i_clk) begin
    if (cnt == 0 && i_go)
      cnt <= 1;
    else if (cnt == FLEN)
      cnt <= 0;
    else if (cnt != 0)
      cnt <= cnt + 1;
  end
  // Idle bus sits recessive; frame bits change every cycle
  assign o_frame_active = (cnt != 0);
  assign o_sof = (cnt == 1);
  assign o_eof_last = (cnt == FLEN);
  assign o_rxd = (cnt == 0) ? 1'b1 : cnt[0];
endmodule : cgc_bus_node
`default_nettype wire
